/* File: rtl/ivm_pkg.sv */
// Constants for the interrupt vector mapping block
package ivm_pkg;
   localparam int NUM_IRQ = 64;
   localparam int REQ_W   = 6;
   localparam int DATA_W  = 16;
   localparam int ADDR_W  = 6;
   localparam int LEVEL_W = 3;
   localparam int VEC_W   = 8;
   localparam int IVT_W   = 24;

   // Vector numbering and table base
   localparam logic [VEC_W-1:0] VEC_BASE = 8'h08;
   localparam logic [IVT_W-1:0] IVT_BASE = 24'h000014;

   // Register offsets, word index on the plain port
   localparam logic [ADDR_W-1:0] FLAG_OFS = 6'h00;
   localparam logic [ADDR_W-1:0] SET_OFS  = 6'h04;
   localparam logic [ADDR_W-1:0] CLR_OFS  = 6'h08;
   localparam logic [ADDR_W-1:0] EN_OFS   = 6'h0c;
   localparam logic [ADDR_W-1:0] PRIO_OFS = 6'h10;
   localparam logic [ADDR_W-1:0] VEC_OFS  = 6'h20;

   // Reset values
   localparam logic [LEVEL_W-1:0] PRIO_RESET = 3'h4;
   localparam logic [DATA_W-1:0]  RD_IDLE    = 16'h0000;

   // Priority field pitch inside a priority word, and flag bits per word
   localparam int PRIO_PITCH = 4;
   localparam int FLAG_BITS  = 16;

   // Reserved request numbers and the optional CAN and PWM request numbers
   localparam logic [NUM_IRQ-1:0] RESERVED_MASK = 64'hfdf9_ff80_00e0_8000;
   localparam logic [NUM_IRQ-1:0] CAN_MASK      = 64'h0000_000c_0000_0000;
   localparam logic [NUM_IRQ-1:0] PWM_MASK      = 64'h0200_0000_0000_0000;

   // Request numbers of each source group
   localparam int REQ_EXT_PIN [3]   = '{0, 20, 29};
   localparam int REQ_CAPTURE [4]   = '{1, 5, 37, 38};
   localparam int REQ_COMPARE [4]   = '{2, 6, 25, 26};
   localparam int REQ_TIMER [5]     = '{3, 7, 8, 27, 28};
   localparam int REQ_DMA [4]       = '{4, 14, 24, 36};
   localparam int REQ_SER_ERR [2]   = '{9, 32};
   localparam int REQ_SER_DONE [2]  = '{10, 33};
   localparam int REQ_UART_RX [2]   = '{11, 30};
   localparam int REQ_UART_TX [2]   = '{12, 31};
   localparam int REQ_I2C_SLV [2]   = '{16, 49};
   localparam int REQ_I2C_MST [2]   = '{17, 50};
   localparam int REQ_CONVERTER     = 13;
   localparam int REQ_COMPARATOR    = 18;
   localparam int REQ_PIN_CHANGE    = 19;
   localparam int REQ_CAN_RX        = 34;
   localparam int REQ_CAN_EVENT     = 35;
   localparam int REQ_PWM_MATCH     = 57;
endpackage

/* File: rtl/ivm_cand_if.sv */
// Candidate carried between arbitration cells
`timescale 1ns/1ps
interface ivm_cand_if;
   logic                         valid;
   logic [ivm_pkg::LEVEL_W-1:0]  level;
   logic [ivm_pkg::REQ_W-1:0]    num;
   modport src (output valid, output level, output num);
   modport dst (input valid, input level, input num);
endinterface

/* File: rtl/ivm_prio_cell.sv */
// One two-way arbitration cell of the priority tree
`timescale 1ns/1ps
module ivm_prio_cell (
   ivm_cand_if.dst lo_i,
   ivm_cand_if.dst hi_i,
   ivm_cand_if.src win_o
);
   logic take_lo;

   // Higher level wins, equal level keeps the lower number
   assign take_lo = lo_i.valid && (!hi_i.valid || (lo_i.level >= hi_i.level));

   assign win_o.valid = lo_i.valid | hi_i.valid;
   assign win_o.level = take_lo ? lo_i.level : hi_i.level;
   assign win_o.num   = take_lo ? lo_i.num : hi_i.num;
endmodule

/* File: rtl/ivm_top.sv */
// Interrupt vector mapping: flags, enables, priorities and vector selection
`timescale 1ns/1ps
module ivm_top #(
   parameter bit HAS_CAN = 1'b1,
   parameter bit HAS_PWM = 1'b1
) (
   input  wire logic                          mclk_i,
   input  wire logic                          rst_i,
   input  wire logic [ivm_pkg::ADDR_W-1:0]    reg_addr_i,
   input  wire logic [ivm_pkg::DATA_W-1:0]    reg_wdata_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   output logic      [ivm_pkg::DATA_W-1:0]    reg_rdata_o,
   input  wire logic [2:0]                    ext_pin_irq_i,
   input  wire logic [3:0]                    capture_unit_i,
   input  wire logic [3:0]                    compare_unit_i,
   input  wire logic [4:0]                    timer_i,
   input  wire logic [3:0]                    dma_channel_done_i,
   input  wire logic [1:0]                    serial_port_error_i,
   input  wire logic [1:0]                    serial_port_done_i,
   input  wire logic [1:0]                    uart_receive_i,
   input  wire logic [1:0]                    uart_transmit_i,
   input  wire logic [1:0]                    i2c_slave_event_i,
   input  wire logic [1:0]                    i2c_master_event_i,
   input  wire logic                          converter_done_i,
   input  wire logic                          comparator_combined_event_i,
   input  wire logic                          pin_change_notice_i,
   input  wire logic                          can_receive_ready_i,
   input  wire logic                          can_event_i,
   input  wire logic                          pwm_special_match_i,
   output logic                               irq_o,
   output logic                               vec_valid_o,
   output logic      [ivm_pkg::REQ_W-1:0]     vec_req_o,
   output logic      [ivm_pkg::VEC_W-1:0]     vec_num_o,
   output logic      [ivm_pkg::IVT_W-1:0]     vec_addr_o,
   output logic      [ivm_pkg::LEVEL_W-1:0]   vec_level_o
);
   localparam int N  = ivm_pkg::NUM_IRQ;
   localparam int DW = ivm_pkg::DATA_W;
   localparam int FB = ivm_pkg::FLAG_BITS;
   localparam int PP = ivm_pkg::PRIO_PITCH;

   // Implemented request numbers for this variant
   localparam logic [N-1:0] IMPL = ~ivm_pkg::RESERVED_MASK
      & ~(HAS_CAN ? '0 : ivm_pkg::CAN_MASK)
      & ~(HAS_PWM ? '0 : ivm_pkg::PWM_MASK);

   logic [N-1:0]                     raw_req;
   logic [N-1:0]                     flag;
   logic [N-1:0]                     enable;
   logic [ivm_pkg::LEVEL_W-1:0]      prio [N];
   logic [N-1:0]                     sw_set;
   logic [N-1:0]                     sw_clr;
   logic [N-1:0]                     next_flag;
   logic [1:0]                       word_sel;
   logic [3:0]                       prio_sel;
   logic                             hit_flag;
   logic                             hit_set;
   logic                             hit_clr;
   logic                             hit_en;
   logic                             hit_prio;
   logic                             hit_vec;
   logic [DW-1:0]                    next_rdata;
   logic [ivm_pkg::VEC_W-1:0]        next_vec_num;
   logic [ivm_pkg::IVT_W-1:0]        next_vec_addr;

   // Source routing onto request numbers
   always_comb begin
      raw_req = '0;
      for (int i = 0; i < 3; i++) begin
         raw_req[ivm_pkg::REQ_EXT_PIN[i]] = ext_pin_irq_i[i];
      end
      for (int i = 0; i < 4; i++) begin
         raw_req[ivm_pkg::REQ_CAPTURE[i]] = capture_unit_i[i];
         raw_req[ivm_pkg::REQ_COMPARE[i]] = compare_unit_i[i];
         raw_req[ivm_pkg::REQ_DMA[i]]     = dma_channel_done_i[i];
      end
      for (int i = 0; i < 5; i++) begin
         raw_req[ivm_pkg::REQ_TIMER[i]] = timer_i[i];
      end
      for (int i = 0; i < 2; i++) begin
         raw_req[ivm_pkg::REQ_SER_ERR[i]]  = serial_port_error_i[i];
         raw_req[ivm_pkg::REQ_SER_DONE[i]] = serial_port_done_i[i];
         raw_req[ivm_pkg::REQ_UART_RX[i]]  = uart_receive_i[i];
         raw_req[ivm_pkg::REQ_UART_TX[i]]  = uart_transmit_i[i];
         raw_req[ivm_pkg::REQ_I2C_SLV[i]]  = i2c_slave_event_i[i];
         raw_req[ivm_pkg::REQ_I2C_MST[i]]  = i2c_master_event_i[i];
      end
      raw_req[ivm_pkg::REQ_CONVERTER]  = converter_done_i;
      raw_req[ivm_pkg::REQ_COMPARATOR] = comparator_combined_event_i;
      raw_req[ivm_pkg::REQ_PIN_CHANGE] = pin_change_notice_i;
      raw_req[ivm_pkg::REQ_CAN_RX]     = can_receive_ready_i;
      raw_req[ivm_pkg::REQ_CAN_EVENT]  = can_event_i;
      raw_req[ivm_pkg::REQ_PWM_MATCH]  = pwm_special_match_i;
      raw_req = raw_req & IMPL;
   end

   // Address decode
   assign word_sel = reg_addr_i[1:0];
   assign prio_sel = reg_addr_i[3:0];
   assign hit_flag = (reg_addr_i[5:2] == ivm_pkg::FLAG_OFS[5:2]);
   assign hit_set  = (reg_addr_i[5:2] == ivm_pkg::SET_OFS[5:2]);
   assign hit_clr  = (reg_addr_i[5:2] == ivm_pkg::CLR_OFS[5:2]);
   assign hit_en   = (reg_addr_i[5:2] == ivm_pkg::EN_OFS[5:2]);
   assign hit_prio = (reg_addr_i[5:4] == ivm_pkg::PRIO_OFS[5:4]);
   assign hit_vec  = (reg_addr_i == ivm_pkg::VEC_OFS);

   // Software set and clear strobes, one word at a time
   always_comb begin
      sw_set = '0;
      sw_clr = '0;
      if (reg_wr_i && hit_set) begin
         sw_set[word_sel*FB +: FB] = reg_wdata_i;
      end
      if (reg_wr_i && hit_clr) begin
         sw_clr[word_sel*FB +: FB] = reg_wdata_i;
      end
   end

   // Hardware and software set win over a clear in the same cycle
   assign next_flag = ((flag & ~sw_clr) | raw_req | sw_set) & IMPL;

   // Sticky request flags
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         flag <= '0;
      end else begin
         flag <= next_flag;
      end
   end

   // Enable words
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         enable <= '0;
      end else if (reg_wr_i && hit_en) begin
         enable[word_sel*FB +: FB] <= reg_wdata_i & IMPL[word_sel*FB +: FB];
      end
   end

   // Priority fields, four per word
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int n = 0; n < N; n++) begin
            prio[n] <= IMPL[n] ? ivm_pkg::PRIO_RESET : '0;
         end
      end else if (reg_wr_i && hit_prio) begin
         for (int f = 0; f < PP; f++) begin
            if (IMPL[prio_sel*PP+f]) begin
               prio[prio_sel*PP+f] <= reg_wdata_i[f*PP +: ivm_pkg::LEVEL_W];
            end
         end
      end
   end

   // Read data mux
   always_comb begin
      next_rdata = ivm_pkg::RD_IDLE;
      if (hit_flag) begin
         next_rdata = flag[word_sel*FB +: FB];
      end else if (hit_en) begin
         next_rdata = enable[word_sel*FB +: FB];
      end else if (hit_prio) begin
         for (int f = 0; f < PP; f++) begin
            next_rdata[f*PP +: ivm_pkg::LEVEL_W] = prio[prio_sel*PP+f];
         end
      end else if (hit_vec) begin
         next_rdata = {vec_valid_o, 4'h0, vec_level_o, 2'h0, vec_req_o};
      end
   end

   // Read data valid in the cycle after the read strobe
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= ivm_pkg::RD_IDLE;
      end else if (reg_rd_i) begin
         reg_rdata_o <= next_rdata;
      end else begin
         reg_rdata_o <= ivm_pkg::RD_IDLE;
      end
   end

   // Priority tree, leaves at 64..127, root at 1
   ivm_cand_if node [2*N] ();

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_leaf
         assign node[N+g].valid = flag[g] & enable[g];
         assign node[N+g].level = prio[g];
         assign node[N+g].num   = ivm_pkg::REQ_W'(g);
      end
      for (g = 1; g < N; g++) begin : g_cell
         ivm_prio_cell u_cell (
            .lo_i  (node[2*g]),
            .hi_i  (node[2*g+1]),
            .win_o (node[g])
         );
      end
      assign node[0].valid = 1'b0;
      assign node[0].level = '0;
      assign node[0].num   = '0;
   endgenerate

   // Vector number and table address of the winner
   assign next_vec_num  = ivm_pkg::VEC_BASE + ivm_pkg::VEC_W'(node[1].num);
   assign next_vec_addr = ivm_pkg::IVT_BASE + {17'h00000, node[1].num, 1'b0};

   // Registered vector presented to the core
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         vec_valid_o <= 1'b0;
         vec_req_o   <= '0;
         vec_num_o   <= '0;
         vec_addr_o  <= '0;
         vec_level_o <= '0;
      end else begin
         vec_valid_o <= node[1].valid;
         vec_req_o   <= node[1].num;
         vec_num_o   <= next_vec_num;
         vec_addr_o  <= next_vec_addr;
         vec_level_o <= node[1].level;
      end
   end

   // Level interrupt while any enabled flag is set
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(flag & enable);
      end
   end
endmodule

/* File: sim/ivm_properties.sv */
// Concurrent checks on the vector mapping block ports
`timescale 1ns/1ps
module ivm_properties (
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic [5:0]  reg_addr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic [2:0]  ext_pin_irq_i,
   input wire logic [4:0]  timer_i,
   input wire logic        pwm_special_match_i,
   input wire logic        irq_o,
   input wire logic        vec_valid_o,
   input wire logic [5:0]  vec_req_o,
   input wire logic [7:0]  vec_num_o,
   input wire logic [23:0] vec_addr_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   // Source pulse followed at once by a read of its flag word
   sequence ext0_read;
      ext_pin_irq_i[0] ##1 (reg_rd_i && reg_addr_i == 6'h00);
   endsequence
   sequence timer5_read;
      timer_i[4] ##1 (reg_rd_i && reg_addr_i == 6'h01);
   endsequence
   sequence pwm_read;
      pwm_special_match_i ##1 (reg_rd_i && reg_addr_i == 6'h03);
   endsequence

   a_ext0_flag_bit: assert property (ext0_read |=> reg_rdata_o[0])
      else $error("pin zero flag not at bit 0");
   a_timer5_flag_bit: assert property (timer5_read |=> reg_rdata_o[12])
      else $error("timer five flag misplaced");
   a_pwm_flag_bit: assert property (pwm_read |=> reg_rdata_o[9])
      else $error("pwm match flag misplaced");
   a_vec_num_sum: assert property (vec_valid_o |-> vec_num_o == {2'b00, vec_req_o} + 8'h08)
      else $error("vector number wrong");
   a_vec_addr_sum: assert property (vec_valid_o |->
      vec_addr_o == 24'h000014 + {17'h00000, vec_req_o, 1'b0})
      else $error("vector address wrong");
   a_ext0_vector: assert property (vec_valid_o && vec_req_o == 6'h00 |->
      vec_num_o == 8'h08 && vec_addr_o == 24'h000014) else $error("pin zero vector wrong");
   a_irq_vec_agree: assert property (irq_o == vec_valid_o)
      else $error("interrupt and vector valid differ");
   a_no_reserved_win: assert property (vec_valid_o |-> !ivm_pkg::RESERVED_MASK[vec_req_o])
      else $error("reserved request won");
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
      else $error("read data not idle");
endmodule

bind ivm_top ivm_properties u_props (.mclk_i, .rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
   .ext_pin_irq_i, .timer_i, .pwm_special_match_i, .irq_o, .vec_valid_o, .vec_req_o,
   .vec_num_o, .vec_addr_o);

/* File: sim/ivm_core_model.sv */
// Core side model latching the vector address it fetches
`timescale 1ns/1ps
module ivm_core_model (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        irq_i,
   input  wire logic [23:0] vec_addr_i,
   output logic      [23:0] fetch_addr_o
);
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         fetch_addr_o <= 24'h000000;
      end else if (irq_i) begin
         fetch_addr_o <= vec_addr_i;
      end
   end
endmodule

/* File: sim/interrupt_vector_mapping_tb.sv */
// Self-checking bench of the vector mapping block
`timescale 1ns/1ps
module interrupt_vector_mapping_tb;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [5:0]  reg_addr_i = 6'h00;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [15:0] reg_rdata_o;
   logic [37:0] src = '0;
   logic        irq_o;
   logic        vec_valid_o;
   logic [5:0]  vec_req_o;
   logic [7:0]  vec_num_o;
   logic [23:0] vec_addr_o;
   logic [23:0] core_addr;
   logic [2:0]  vec_level_o;
   int          fail_count = 0;
   int          compares = 0;
   int          req_tab [38] = '{0, 20, 29, 1, 5, 37, 38, 2, 6, 25, 26, 3, 7, 8, 27, 28,
      4, 14, 24, 36, 9, 32, 10, 33, 11, 30, 12, 31, 16, 49, 17, 50, 13, 18, 19, 34, 35, 57};

   always #25 mclk_i = ~mclk_i;

   ivm_top u_dut (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .ext_pin_irq_i(src[2:0]), .capture_unit_i(src[6:3]),
      .compare_unit_i(src[10:7]), .timer_i(src[15:11]), .dma_channel_done_i(src[19:16]),
      .serial_port_error_i(src[21:20]), .serial_port_done_i(src[23:22]),
      .uart_receive_i(src[25:24]), .uart_transmit_i(src[27:26]),
      .i2c_slave_event_i(src[29:28]), .i2c_master_event_i(src[31:30]),
      .converter_done_i(src[32]), .comparator_combined_event_i(src[33]),
      .pin_change_notice_i(src[34]), .can_receive_ready_i(src[35]), .can_event_i(src[36]),
      .pwm_special_match_i(src[37]), .irq_o, .vec_valid_o, .vec_req_o, .vec_num_o,
      .vec_addr_o, .vec_level_o);

   ivm_core_model u_core (.mclk_i, .rst_i, .irq_i(irq_o), .vec_addr_i(vec_addr_o),
      .fetch_addr_o(core_addr));

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   task automatic test_reset_values;
      logic [15:0] d;
      rd(6'h0c, d);
      chk(d, 16'h0000);
      rd(6'h10, d);
      chk(d, 16'h4444);
      rd(6'h13, d);
      chk(d, 16'h0444);
      rd(6'h3f, d);
      chk(d, 16'h0000);
   endtask

   task automatic test_routing;
      int n;
      for (int i = 0; i < 38; i++) begin
         n = req_tab[i];
         wr(6'h0c + 6'(n / 16), 16'h0001 << (n % 16));
         @(posedge mclk_i);
         src[i] <= 1'b1;
         @(posedge mclk_i);
         src[i] <= 1'b0;
         reg_rd_i <= 1'b1;
         reg_addr_i <= 6'(n / 16);
         @(posedge mclk_i);
         reg_rd_i <= 1'b0;
         #1 chk(reg_rdata_o, 16'h0001 << (n % 16));
         chk({irq_o, vec_req_o}, 24'(n) + 24'h40);
         chk(vec_num_o, 24'(n) + 24'h8);
         wr(6'h08 + 6'(n / 16), 16'h0001 << (n % 16));
         wr(6'h0c + 6'(n / 16), 16'h0000);
         #1 chk(core_addr, 24'h000014 + 24'(2 * n));
         chk(irq_o, 1'b0);
      end
   endtask

   task automatic test_priority;
      logic [15:0] d;
      wr(6'h0c, 16'h0022);
      @(posedge mclk_i);
      src[4:3] <= 2'b11;
      @(posedge mclk_i);
      src[4:3] <= 2'b00;
      repeat (2) @(posedge mclk_i);
      #1 chk({vec_level_o, vec_req_o}, {3'h4, 6'h01});
      rd(6'h20, d);
      chk(d, 16'h8401);
      wr(6'h11, 16'h4474);
      repeat (2) @(posedge mclk_i);
      #1 chk({vec_level_o, vec_req_o}, {3'h7, 6'h05});
      wr(6'h11, 16'h4404);
      wr(6'h08, 16'h0002);
      repeat (2) @(posedge mclk_i);
      #1 chk({vec_level_o, vec_req_o}, {3'h0, 6'h05});
      wr(6'h08, 16'h0020);
      wr(6'h0c, 16'h0000);
      repeat (2) @(posedge mclk_i);
      #1 chk({irq_o, vec_valid_o}, 2'b00);
      // Source event and clear in one cycle: the event wins
      @(posedge mclk_i);
      src[3] <= 1'b1;
      reg_wr_i <= 1'b1;
      reg_addr_i <= 6'h08;
      reg_wdata_i <= 16'h0002;
      @(posedge mclk_i);
      src[3] <= 1'b0;
      reg_wr_i <= 1'b0;
      rd(6'h00, d);
      chk(d, 16'h0002);
      wr(6'h08, 16'h0002);
      rd(6'h00, d);
      chk(d, 16'h0000);
   endtask

   task automatic test_reserved;
      logic [15:0] d;
      wr(6'h0c, 16'hffff);
      wr(6'h04, 16'h8000);
      rd(6'h0c, d);
      chk(d, 16'h7fff);
      rd(6'h00, d);
      chk({irq_o, d}, 17'h00000);
      wr(6'h0e, 16'hffff);
      rd(6'h0e, d);
      chk(d, 16'h007f);
      wr(6'h0f, 16'hffff);
      rd(6'h0f, d);
      chk(d, 16'h0206);
      wr(6'h07, 16'h0200);
      repeat (2) @(posedge mclk_i);
      #1 chk({vec_num_o, vec_addr_o[7:0]}, {8'h41, 8'h86});
      wr(6'h0b, 16'h0200);
      wr(6'h0c, 16'h0000);
      wr(6'h0e, 16'h0000);
      wr(6'h0f, 16'h0000);
   endtask

   task automatic tally_and_finish;
      if (fail_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      test_reset_values();
      test_routing();
      test_priority();
      test_reserved();
      tally_and_finish();
   end

   initial begin
      #1_000_000;
      fail_count++;
      tally_and_finish();
   end
endmodule
